//--- prs_result_regs.sv
// Proximity sensor register bank: command pointer, control, status, result and offset.
//
// Overview of operation
// - Diode field routes to none, first, second.
// - Gain field picks one, two, four, eight.
// - Revision read-only, low nibble revision, high zero.
// - Identification read-only fixed code, writes ignored.
// - Status bit 6 flags saturated measurement.
// - Status bit 5 mirrors asserted interrupt.
// - Status bit 1 set after integration when enabled.
// - Status read-only, bits 4:2 read zero.
// - Result 16 bits at low/high byte registers.
// - Low byte read snapshots high byte shadow.
// - High byte stays coherent across new conversions.
// - Offset sign: clear negative, set positive.
// - Offset magnitude scaled by gain, drive, pulses.
// - Offset register resets to zero.
// - Interrupt and data pins are open-drain; clock pin is input only.
// - Enable bit 2 switches proximity function.
// - Auto-increment type advances register pointer.
// - Special code 00101 clears pending interrupt.
`include "prs_defs.svh"

module prs_result_regs
#(
   parameter logic [7:0] P_PART_ID  = `PRS_ID_VALUE,
   parameter logic [3:0] P_DIE_REV  = `PRS_REV_VALUE
)
(
   // Clock and reset.
   input  wire logic        i_core_clk,
   input  wire logic        i_sys_rst,
   // Serial bus pins.
   input  wire logic        i_scl,
   input  wire logic        i_sda,
   output logic             o_sda_out,
   output logic             o_sda_oe_n,
   // Interrupt pin.
   output logic             o_int_out,
   output logic             o_int_oe_n,
   // Measurement engine side.
   input  wire logic        i_conv_done,
   input  wire logic [15:0] i_conv_result,
   input  wire logic        i_conv_saturated,
   input  wire logic        i_irq_event,
   input  wire logic [7:0]  i_led_pulse_count,
   output logic             o_irq_clear,
   output logic             o_prox_func_enable,
   // Analog controls.
   output logic [1:0]       o_diode_route,
   output logic [3:0]       o_gain_mult,
   output logic [1:0]       o_led_drive_strength,
   output logic             o_offset_sign,
   output logic [17:0]      o_offset_shift
);

   logic        wr_stb;
   logic        wr_first;
   logic [7:0]  wr_data;
   logic        rd_req;
   logic [7:0]  rd_data;
   logic [7:0]  status_val;
   logic [4:0]  ptr_reg;
   logic [1:0]  type_reg;
   logic [7:0]  enable_reg;
   logic [7:0]  control_reg;
   logic [7:0]  offset_reg;
   logic [15:0] result_reg;
   logic [7:0]  shadow_reg;
   logic        sat_reg;
   logic        valid_reg;
   logic        irq_reg;
   logic        cmd_stb;
   logic        clr_req;
   logic        step_ptr;
   logic [14:0] mag_prod;

   ////////////////////////////////////////////////////////////////////////////
   // Serial bus target.
   prs_i2c_target u_target
   (
      .i_core_clk (i_core_clk),
      .i_sys_rst  (i_sys_rst),
      .i_scl      (i_scl),
      .i_sda      (i_sda),
      .o_sda_out  (o_sda_out),
      .o_sda_oe_n (o_sda_oe_n),
      .o_wr_stb   (wr_stb),
      .o_wr_first (wr_first),
      .o_wr_data  (wr_data),
      .o_rd_req   (rd_req),
      .i_rd_data  (rd_data)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Command decode: first byte of a write with the select bit set.
   assign cmd_stb  = wr_stb & wr_first & wr_data[`PRS_CMD_SEL_BIT];
   assign clr_req  = cmd_stb & (wr_data[6:5] == `PRS_TYPE_SPECIAL) &
                     (wr_data[4:0] == `PRS_SF_IRQ_CLEAR);
   assign step_ptr = ((wr_stb & ~wr_first) | rd_req) & (type_reg == `PRS_TYPE_AUTO);

   // Register pointer and transaction type.
   always_ff @(posedge i_core_clk)
   begin
      if (i_sys_rst)
      begin
         ptr_reg  <= 5'h00;
         type_reg <= `PRS_TYPE_REPEAT;
      end
      else if (cmd_stb)
      begin
         type_reg <= wr_data[6:5];
         if (wr_data[6:5] != `PRS_TYPE_SPECIAL)
         begin
            ptr_reg <= wr_data[4:0];
         end
      end
      else if (step_ptr)
      begin
         ptr_reg <= ptr_reg + 5'h01;
      end
   end

   // Writable registers; read-only offsets fall through untouched.
   always_ff @(posedge i_core_clk)
   begin
      if (i_sys_rst)
      begin
         enable_reg  <= `PRS_ENABLE_RST;
         control_reg <= `PRS_CONTROL_RST;
         offset_reg  <= `PRS_OFFSET_RST;
      end
      else if (wr_stb && !wr_first)
      begin
         unique case (ptr_reg)
            `PRS_ADDR_ENABLE:  enable_reg  <= wr_data;
            `PRS_ADDR_CONTROL: control_reg <= wr_data;
            `PRS_ADDR_OFFSET:  offset_reg  <= wr_data;
            default:
            begin
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Result and saturation captured at each finished conversion.
   always_ff @(posedge i_core_clk)
   begin
      if (i_sys_rst)
      begin
         result_reg <= 16'h0000;
         sat_reg    <= 1'b0;
      end
      else if (i_conv_done)
      begin
         result_reg <= i_conv_result;
         sat_reg    <= i_conv_saturated;
      end
   end

   // Valid flag: first finished cycle while enabled; cleared when disabled.
   always_ff @(posedge i_core_clk)
   begin
      if (i_sys_rst || !enable_reg[`PRS_EN_PROX_BIT])
      begin
         valid_reg <= 1'b0;
      end
      else if (i_conv_done)
      begin
         valid_reg <= 1'b1;
      end
   end

   // High byte snapshot taken as the low byte is fetched.
   always_ff @(posedge i_core_clk)
   begin
      if (i_sys_rst)
      begin
         shadow_reg <= 8'h00;
      end
      else if (rd_req && ptr_reg == `PRS_ADDR_RES_LO)
      begin
         shadow_reg <= result_reg[15:8];
      end
   end

   // Pending interrupt; a new event wins over a clear in the same cycle.
   always_ff @(posedge i_core_clk)
   begin
      if (i_sys_rst)
      begin
         irq_reg     <= 1'b0;
         o_irq_clear <= 1'b0;
      end
      else
      begin
         o_irq_clear <= clr_req;
         if (i_irq_event)
         begin
            irq_reg <= 1'b1;
         end
         else if (clr_req)
         begin
            irq_reg <= 1'b0;
         end
      end
   end

   // Interrupt pin only pulls low while an interrupt is pending.
   assign o_int_out  = 1'b0;
   assign o_int_oe_n = ~irq_reg;

   ////////////////////////////////////////////////////////////////////////////
   // Status byte with reserved bits held at zero.
   always_comb
   begin
      status_val                    = 8'h00;
      status_val[`PRS_ST_SAT_BIT]   = sat_reg;
      status_val[`PRS_ST_IRQ_BIT]   = irq_reg;
      status_val[`PRS_ST_VALID_BIT] = valid_reg;
   end

   // Read data for the byte at the pointer.
   always_comb
   begin
      rd_data = 8'h00;
      unique case (ptr_reg)
         `PRS_ADDR_ENABLE:   rd_data = enable_reg;
         `PRS_ADDR_CONTROL:  rd_data = control_reg;
         `PRS_ADDR_REVISION: rd_data = {4'h0, P_DIE_REV};
         `PRS_ADDR_ID:       rd_data = P_PART_ID;
         `PRS_ADDR_STATUS:   rd_data = status_val;
         `PRS_ADDR_RES_LO:   rd_data = result_reg[7:0];
         `PRS_ADDR_RES_HI:   rd_data = shadow_reg;
         `PRS_ADDR_OFFSET:   rd_data = offset_reg;
         default:            rd_data = 8'h00;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   // Analog control outputs; the reserved diode code routes nowhere.
   assign mag_prod = {8'h00, offset_reg[6:0]} * {7'h00, i_led_pulse_count};

   always_ff @(posedge i_core_clk)
   begin
      if (i_sys_rst)
      begin
         o_diode_route        <= 2'h0;
         o_gain_mult          <= 4'h1;
         o_led_drive_strength <= 2'h0;
         o_offset_sign        <= 1'b0;
         o_offset_shift       <= 18'h00000;
         o_prox_func_enable   <= 1'b0;
      end
      else
      begin
         unique case (control_reg[5:4])
            `PRS_DIODE_FIRST:  o_diode_route <= 2'h1;
            `PRS_DIODE_SECOND: o_diode_route <= 2'h2;
            default:           o_diode_route <= 2'h0;
         endcase
         o_gain_mult          <= 4'h1 << control_reg[3:2];
         o_led_drive_strength <= control_reg[7:6];
         o_offset_sign        <= offset_reg[`PRS_OFS_SIGN_BIT];
         o_offset_shift       <= ({3'h0, mag_prod} << control_reg[3:2]) >> control_reg[7:6];
         o_prox_func_enable   <= enable_reg[`PRS_EN_PROX_BIT];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Checks on the register behaviour.
   default clocking cb @(posedge i_core_clk);
   endclocking
   default disable iff (i_sys_rst);

   diode_route_a:
      assert property (control_reg[5:4] == `PRS_DIODE_SECOND |=> o_diode_route == 2'h2)
      else $error("Second diode not routed.");
   gain_mult_a:
      assert property (##1 o_gain_mult == (4'h1 << $past(control_reg[3:2])))
      else $error("Gain multiplier wrong.");
   revision_read_a:
      assert property (ptr_reg == `PRS_ADDR_REVISION |-> rd_data == {4'h0, P_DIE_REV})
      else $error("Revision byte wrong.");
   id_read_a:
      assert property (ptr_reg == `PRS_ADDR_ID |-> rd_data == P_PART_ID)
      else $error("Identification byte wrong.");
   sat_capture_a:
      assert property (i_conv_done && i_conv_saturated |=> status_val[`PRS_ST_SAT_BIT])
      else $error("Saturation not flagged.");
   irq_mirror_a:
      assert property (status_val[`PRS_ST_IRQ_BIT] == !o_int_oe_n)
      else $error("Interrupt bit and pin disagree.");
   valid_set_a:
      assert property (i_conv_done && enable_reg[`PRS_EN_PROX_BIT] && !wr_stb |=> valid_reg)
      else $error("Valid flag not set.");
   status_rsvd_a:
      assert property (ptr_reg == `PRS_ADDR_STATUS |-> rd_data[4:2] == 3'h0 && !rd_data[7] && !rd_data[0])
      else $error("Status reserved bits set.");
   shadow_load_a:
      assert property (rd_req && ptr_reg == `PRS_ADDR_RES_LO |=> shadow_reg == $past(result_reg[15:8]))
      else $error("Shadow not loaded.");
   shadow_hold_a:
      assert property (!(rd_req && ptr_reg == `PRS_ADDR_RES_LO) |=> $stable(shadow_reg))
      else $error("Shadow changed without low read.");
   offset_idle_a:
      assert property ($rose(!i_sys_rst) |-> offset_reg == 8'h00 ##1 o_offset_shift == 18'h00000)
      else $error("Offset not zero after reset.");
   ptr_step_a:
      assert property (rd_req && type_reg == `PRS_TYPE_AUTO |=> ptr_reg == $past(ptr_reg) + 5'h01)
      else $error("Pointer did not advance.");
   irq_clear_a:
      assert property (clr_req && !i_irq_event |=> !irq_reg ##0 o_irq_clear)
      else $error("Interrupt not cleared.");
   ro_write_a:
      assert property (wr_stb && !wr_first && ptr_reg == `PRS_ADDR_ID |=> $stable(enable_reg) && $stable(control_reg))
      else $error("Read-only write altered state.");

   result_pair_c: cover property (rd_req && ptr_reg == `PRS_ADDR_RES_LO ##[1:400] rd_req && ptr_reg == `PRS_ADDR_RES_HI);
   irq_clear_c:   cover property (irq_reg ##[1:800] !irq_reg);
   valid_rise_c:  cover property ($rose(valid_reg));
   offset_wr_c:   cover property (wr_stb && !wr_first && ptr_reg == `PRS_ADDR_OFFSET);

endmodule

//--- prs_defs.svh
// Constants for the proximity sensor result register bank.
`ifndef PRS_DEFS_SVH
`define PRS_DEFS_SVH

// Register offsets, as carried in the command byte address field.
`define PRS_ADDR_ENABLE   5'h00
`define PRS_ADDR_CONTROL  5'h0f
`define PRS_ADDR_REVISION 5'h11
`define PRS_ADDR_ID       5'h12
`define PRS_ADDR_STATUS   5'h13
`define PRS_ADDR_RES_LO   5'h18
`define PRS_ADDR_RES_HI   5'h19
`define PRS_ADDR_OFFSET   5'h1e

// Command byte fields and codes.
`define PRS_CMD_SEL_BIT   7
`define PRS_TYPE_REPEAT   2'h0
`define PRS_TYPE_AUTO     2'h1
`define PRS_TYPE_SPECIAL  2'h3
`define PRS_SF_IRQ_CLEAR  5'h05

// Field positions.
`define PRS_EN_PROX_BIT   2
`define PRS_ST_SAT_BIT    6
`define PRS_ST_IRQ_BIT    5
`define PRS_ST_VALID_BIT  1
`define PRS_OFS_SIGN_BIT  7

// Diode selection codes.
`define PRS_DIODE_NONE    2'h0
`define PRS_DIODE_FIRST   2'h1
`define PRS_DIODE_SECOND  2'h2

// Reset values.
`define PRS_ENABLE_RST    8'h00
`define PRS_CONTROL_RST   8'h00
`define PRS_OFFSET_RST    8'h00

// Bus address and identity values; the identity values are arbitrary.
`define PRS_BUS_ADDR      7'h39
`define PRS_REV_VALUE     4'h1
`define PRS_ID_VALUE      8'h5a

// Bit count of one serial byte.
`define PRS_BITS_PER_BYTE 4'h8

`endif

//--- prs_pkg.sv
// Types shared by the proximity sensor register bank.
package prs_pkg;

   // Serial target states.
   typedef enum logic [2:0]
   {
      PRS_IDLE,
      PRS_ADDR,
      PRS_ACK_ADDR,
      PRS_WRITE,
      PRS_ACK_WRITE,
      PRS_READ,
      PRS_ACK_READ
   } prs_tgt_state_t;

endpackage

//--- prs_i2c_target.sv
// Serial bus target: byte framing, addressing and open-drain data drive.
`include "prs_defs.svh"

module prs_i2c_target
(
   // Clock and reset.
   input  wire logic       i_core_clk,
   input  wire logic       i_sys_rst,
   // Bus pins.
   input  wire logic       i_scl,
   input  wire logic       i_sda,
   output logic            o_sda_out,
   output logic            o_sda_oe_n,
   // Byte side.
   output logic            o_wr_stb,
   output logic            o_wr_first,
   output logic [7:0]      o_wr_data,
   output logic            o_rd_req,
   input  wire logic [7:0] i_rd_data
);

   logic [2:0]               scl_reg;
   logic [2:0]               sda_reg;
   prs_pkg::prs_tgt_state_t  state_reg;
   logic [3:0]               cnt_reg;
   logic [7:0]               sh_reg;
   logic                     rw_reg;
   logic                     first_reg;
   logic                     nack_reg;
   logic                     drv_reg;
   logic                     scl_rise;
   logic                     scl_fall;
   logic                     start_evt;
   logic                     stop_evt;

   ////////////////////////////////////////////////////////////////////////////
   // Two-stage synchronisers plus one history stage for edge finding.
   always_ff @(posedge i_core_clk)
   begin
      if (i_sys_rst)
      begin
         scl_reg <= 3'h7;
         sda_reg <= 3'h7;
      end
      else
      begin
         scl_reg <= {scl_reg[1:0], i_scl};
         sda_reg <= {sda_reg[1:0], i_sda};
      end
   end

   // Edge and frame condition decode from the synchronised stages only.
   assign scl_rise  = scl_reg[1] & ~scl_reg[2];
   assign scl_fall  = ~scl_reg[1] & scl_reg[2];
   assign start_evt = scl_reg[1] & scl_reg[2] & ~sda_reg[1] & sda_reg[2];
   assign stop_evt  = scl_reg[1] & scl_reg[2] & sda_reg[1] & ~sda_reg[2];

   // Data only ever pulls low.
   assign o_sda_out  = 1'b0;
   assign o_sda_oe_n = ~drv_reg;

   // A read byte is fetched on the falling edge that starts it.
   assign o_rd_req = scl_fall & ((state_reg == prs_pkg::PRS_ACK_ADDR & rw_reg) |
                                 (state_reg == prs_pkg::PRS_ACK_READ & ~nack_reg));

   ////////////////////////////////////////////////////////////////////////////
   // Byte framing state machine.
   always_ff @(posedge i_core_clk)
   begin
      if (i_sys_rst)
      begin
         state_reg  <= prs_pkg::PRS_IDLE;
         cnt_reg    <= 4'h0;
         sh_reg     <= 8'h00;
         rw_reg     <= 1'b0;
         first_reg  <= 1'b0;
         nack_reg   <= 1'b0;
         drv_reg    <= 1'b0;
         o_wr_stb   <= 1'b0;
         o_wr_first <= 1'b0;
         o_wr_data  <= 8'h00;
      end
      else
      begin
         o_wr_stb <= 1'b0;
         if (start_evt)
         begin
            state_reg <= prs_pkg::PRS_ADDR;
            cnt_reg   <= 4'h0;
            drv_reg   <= 1'b0;
            first_reg <= 1'b1;
         end
         else if (stop_evt)
         begin
            state_reg <= prs_pkg::PRS_IDLE;
            drv_reg   <= 1'b0;
         end
         else
         begin
            unique case (state_reg)
               prs_pkg::PRS_IDLE:
               begin
               end
               prs_pkg::PRS_ADDR, prs_pkg::PRS_WRITE:
               begin
                  if (scl_rise)
                  begin
                     sh_reg  <= {sh_reg[6:0], sda_reg[1]};
                     cnt_reg <= cnt_reg + 4'h1;
                  end
                  else if (scl_fall && cnt_reg == `PRS_BITS_PER_BYTE)
                  begin
                     if (state_reg == prs_pkg::PRS_WRITE)
                     begin
                        o_wr_stb   <= 1'b1;
                        o_wr_first <= first_reg;
                        o_wr_data  <= sh_reg;
                        drv_reg    <= 1'b1;
                        state_reg  <= prs_pkg::PRS_ACK_WRITE;
                     end
                     else if (sh_reg[7:1] == `PRS_BUS_ADDR)
                     begin
                        drv_reg   <= 1'b1;
                        rw_reg    <= sh_reg[0];
                        state_reg <= prs_pkg::PRS_ACK_ADDR;
                     end
                     else
                     begin
                        state_reg <= prs_pkg::PRS_IDLE;
                     end
                  end
               end
               prs_pkg::PRS_ACK_ADDR, prs_pkg::PRS_ACK_WRITE:
               begin
                  if (scl_fall)
                  begin
                     cnt_reg <= 4'h0;
                     if (state_reg == prs_pkg::PRS_ACK_ADDR && rw_reg)
                     begin
                        sh_reg    <= i_rd_data;
                        drv_reg   <= ~i_rd_data[7];
                        state_reg <= prs_pkg::PRS_READ;
                     end
                     else
                     begin
                        drv_reg   <= 1'b0;
                        first_reg <= (state_reg == prs_pkg::PRS_ACK_ADDR);
                        state_reg <= prs_pkg::PRS_WRITE;
                     end
                  end
               end
               prs_pkg::PRS_READ:
               begin
                  if (scl_rise)
                  begin
                     cnt_reg <= cnt_reg + 4'h1;
                  end
                  else if (scl_fall && cnt_reg == `PRS_BITS_PER_BYTE)
                  begin
                     drv_reg   <= 1'b0;
                     state_reg <= prs_pkg::PRS_ACK_READ;
                  end
                  else if (scl_fall)
                  begin
                     sh_reg  <= {sh_reg[6:0], 1'b0};
                     drv_reg <= ~sh_reg[6];
                  end
               end
               prs_pkg::PRS_ACK_READ:
               begin
                  if (scl_rise)
                  begin
                     nack_reg <= sda_reg[1];
                  end
                  else if (scl_fall && !nack_reg)
                  begin
                     cnt_reg   <= 4'h0;
                     sh_reg    <= i_rd_data;
                     drv_reg   <= ~i_rd_data[7];
                     state_reg <= prs_pkg::PRS_READ;
                  end
                  else if (scl_fall)
                  begin
                     state_reg <= prs_pkg::PRS_IDLE;
                  end
               end
            endcase
         end
      end
   end

endmodule

//--- prs_host_model.sv
// Serial bus host model: an open-drain master that drives the clock and data lines.
module prs_host_model
(
   // Clock.
   input  wire logic i_core_clk,
   // Bus lines.
   input  wire logic i_sda,
   output logic      o_scl,
   output logic      o_sda
);
   timeunit 1ns;
   timeprecision 1ns;

   // Core cycles in one clock phase; four gives a 320 ns serial clock.
   int n_half = 4;

   // Both lines rest released, so the pull-ups hold them high.
   initial o_scl = 1'b1;
   initial o_sda = 1'b1;

   // Waits one phase of the serial clock.
   task automatic half();
      repeat (n_half) @(posedge i_core_clk);
   endtask

   // Moves one bit; a one releases the data line so the device may drive it.
   // Data changes on the edge that lowers the clock, so both phases are equal.
   task automatic bitx(input logic b, output logic r);
      o_sda <= b;
      half();
      o_scl <= 1'b1;
      half();
      r = i_sda;
      o_scl <= 1'b0;
   endtask

   // Start or repeated start: data falls while the clock is high.
   task automatic start();
      @(posedge i_core_clk) o_sda <= 1'b1;
      half();
      o_scl <= 1'b1;
      half();
      o_sda <= 1'b0;
      half();
      o_scl <= 1'b0;
   endtask

   // Stop: data rises while the clock is high.
   task automatic stop();
      @(posedge i_core_clk) o_sda <= 1'b0;
      half();
      o_scl <= 1'b1;
      half();
      o_sda <= 1'b1;
      half();
   endtask

   // One byte and its acknowledge bit; returns what the wire carried.
   task automatic byte_x(input logic [7:0] tx, input logic ack_in, output logic [7:0] rx, output logic ack);
      for (int i = 7; i >= 0; i--)
         bitx(tx[i], rx[i]);
      bitx(ack_in, ack);
   endtask
endmodule

//--- prs_result_regs_tb_top.sv
// Testbench: host model and engine stimulus against the register bank and a reference model.
`include "prs_defs.svh"
module prs_result_regs_tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   localparam logic [7:0] PART_V = 8'hc6; // Arbitrary value.
   localparam logic [3:0] REV_V  = 4'h9;  // Arbitrary value.
   localparam logic [6:0] BA     = `PRS_BUS_ADDR;

   logic        core_clk = 1'b0, sys_rst = 1'b1, scl, sda_h, sda_out, sda_oe_n, int_out, int_oe_n;
   logic        conv_done = 1'b0, conv_sat = 1'b0, irq_ev = 1'b0, irq_clr, prox_en, ofs_sign, ack;
   logic [15:0] conv_res = 16'h0000;
   logic [7:0]  pulses = 8'h00, rx;
   logic [1:0]  route, drive;
   logic [3:0]  gain;
   logic [17:0] ofs_shift;
   logic [7:0]  q[$];
   logic [4:0]  ro[5] = '{5'h11, 5'h12, 5'h13, 5'h18, 5'h19};
   logic [7:0]  rv[5] = '{{4'h0, REV_V}, PART_V, 8'h00, 8'h00, 8'h00};
   int          n_fail = 0, check_count = 0, clr_seen = 0, e_ctl, e_ofs, e_res = 0, old_r;
   wire         sda_w = sda_h & (sda_oe_n | sda_out);

   // Core clock at 25 MHz.
   always #20 core_clk = ~core_clk;

   // Counts the one-cycle interrupt clear pulses.
   always @(posedge core_clk) if (irq_clr === 1'b1) clr_seen++;

   prs_result_regs #(.P_PART_ID(PART_V), .P_DIE_REV(REV_V)) i_dut (.i_core_clk(core_clk), .i_sys_rst(sys_rst),
      .i_scl(scl), .i_sda(sda_w), .o_sda_out(sda_out), .o_sda_oe_n(sda_oe_n), .o_int_out(int_out),
      .o_int_oe_n(int_oe_n), .i_conv_done(conv_done), .i_conv_result(conv_res), .i_conv_saturated(conv_sat),
      .i_irq_event(irq_ev), .i_led_pulse_count(pulses), .o_irq_clear(irq_clr), .o_prox_func_enable(prox_en),
      .o_diode_route(route), .o_gain_mult(gain), .o_led_drive_strength(drive), .o_offset_sign(ofs_sign),
      .o_offset_shift(ofs_shift));
   prs_host_model i_host (.i_core_clk(core_clk), .i_sda(sda_w), .o_scl(scl), .o_sda(sda_h));

   ////////////////////////////////////////////////////////////
   // Compares a seen value with the expected one.
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp)
      begin
         n_fail++;
         $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   // Prints the counts and the verdict, then ends the run.
   task automatic test_done();
      $display("checks %0d mismatches %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   // Pulses the conversion strobe and updates the reference result.
   task automatic conv(input logic [15:0] r, input logic s);
      @(posedge core_clk);
      conv_done <= 1'b1;
      conv_res <= r;
      conv_sat <= s;
      @(posedge core_clk);
      conv_done <= 1'b0;
      e_res = r;
   endtask

   // Sends a command byte and an optional data byte.
   task automatic wr(input logic [7:0] cmd, input logic [7:0] d, input bit has_d);
      i_host.start();
      i_host.byte_x({BA, 1'b0}, 1'b1, rx, ack);
      chk(ack, 1'b0);
      i_host.byte_x(cmd, 1'b1, rx, ack);
      if (has_d)
         i_host.byte_x(d, 1'b1, rx, ack);
      i_host.stop();
   endtask

   // Points at a register and reads n bytes; a conversion may land after the first byte.
   task automatic rd(input logic [7:0] cmd, input int n, input bit mid);
      q = {};
      i_host.start();
      i_host.byte_x({BA, 1'b0}, 1'b1, rx, ack);
      i_host.byte_x(cmd, 1'b1, rx, ack);
      i_host.start();
      i_host.byte_x({BA, 1'b1}, 1'b1, rx, ack);
      for (int k = 0; k < n; k++)
      begin
         i_host.byte_x(8'hff, k == n - 1, rx, ack);
         q.push_back(rx);
         if (mid && k == 0)
            conv(16'(~e_res), 1'b0);
      end
      i_host.stop();
   endtask

   ////////////////////////////////////////////////////////////
   // Main sequence.
   initial
   begin
      void'($urandom(32'h00c3));
      repeat (6) @(posedge core_clk);
      sys_rst <= 1'b0;
      repeat (4) @(posedge core_clk);
      chk(int_oe_n, 1'b1);
      chk(ofs_sign, 1'b0);
      foreach (ro[j])
      begin
         wr({3'b100, ro[j]}, 8'($urandom), 1'b1);
         rd({3'b100, ro[j]}, 1, 1'b0);
         chk(q[0], rv[j]);
      end
      for (int d = 0; d < 3; d++)
         for (int g = 0; g < 4; g++)
         begin
            e_ctl = ($urandom & 8'hc0) | (d << 4) | (g << 2); // Diode code 11 never written.
            e_ofs = $urandom & 8'hff;
            @(posedge core_clk) pulses <= 8'($urandom);
            wr(8'h8f, 8'(e_ctl), 1'b1);
            wr(8'h9e, 8'(e_ofs), 1'b1);
            rd(8'h9e, 1, 1'b0);
            chk(q[0], e_ofs);
            chk(route, d == 1 ? 2'b01 : d == 2 ? 2'b10 : 2'b00);
            chk(gain, 1 << g);
            chk(drive, e_ctl >> 6);
            chk(ofs_sign, e_ofs >> 7);
            chk(ofs_shift, (((e_ofs & 127) * pulses) << g) >> (e_ctl >> 6));
         end
      rd(8'h93, 1, 1'b0);
      chk(q[0], 8'h00);
      wr(8'h80, 8'h04, 1'b1);
      chk(prox_en, 1'b1);
      conv(16'($urandom), 1'b1);
      rd(8'h93, 1, 1'b0);
      chk(q[0], 8'h42);
      conv(16'($urandom), 1'b0);
      @(posedge core_clk) irq_ev <= 1'b1;
      @(posedge core_clk) irq_ev <= 1'b0;
      repeat (2) @(posedge core_clk);
      chk(int_oe_n, 1'b0);
      chk(int_out, 1'b0);
      rd(8'h93, 1, 1'b0);
      chk(q[0], 8'h22);
      clr_seen = 0;
      wr(8'he5, 8'h00, 1'b0);
      chk(clr_seen, 1);
      chk(int_oe_n, 1'b1);
      rd(8'h93, 1, 1'b0);
      chk(q[0], 8'h02);
      old_r = e_res;
      rd(8'hb8, 2, 1'b1); // Two-byte auto-increment fetch.
      chk(q[0], old_r & 8'hff);
      chk(q[1], old_r >> 8);
      rd(8'h99, 1, 1'b0);
      chk(q[0], old_r >> 8);
      rd(8'hb8, 2, 1'b0);
      chk({q[1], q[0]}, e_res);
      wr(8'h80, 8'h00, 1'b1);
      chk(prox_en, 1'b0);
      rd(8'h93, 1, 1'b0);
      chk(q[0], 8'h00);
      test_done();
   end

   // Cuts a hang short.
   initial
   begin
      repeat (100000) @(posedge core_clk);
      n_fail++;
      test_done();
   end
endmodule
